// ===== tssr_defs.svh
// Behaviour
// - Bit 26 picks timer_2 external clock: pin 0 when clear, pin 1 when set.
// - Bit 25 picks timer_1 external clock: pin 0 when clear, pin 1 when set.
// - Bit 24 picks timer_0 external clock: pin 0 when clear, pin 1 when set.
// - Bit 20 picks timer_2 channel 0 capture: channel pin or comparator_0.
// - Bit 18 picks timer_1 channel 0 capture: channel pin or comparator_0.
// - Reserved bits in both routing registers read zero and ignore writes.
// - Serial routing bit 18 enables open-drain drive on serial_port_2.
// - Serial routing bit 17 enables open-drain drive on serial_port_1.
// - Serial routing bit 16 enables open-drain drive on serial_port_0.
// - Bit 6 picks serial_port_1 receive data: receive pin or comparator_0.
// - Bits 5-4 pick serial_port_1 transmit: plain, timer_1 or timer_2 modulated.
// - Bit 2 picks serial_port_0 receive data: receive pin or comparator_0.
// - Bits 1-0 pick serial_port_0 transmit: plain, timer_1 or timer_2 modulated.
`ifndef TSSR_DEFS_SVH
`define TSSR_DEFS_SVH

// Register byte offsets
`define TSSR_TCC_OFF        32'h0000_100C
`define TSSR_SRO_OFF        32'h0000_1010

// Writable bits; everything else is reserved
`define TSSR_TCC_WMASK      32'h0714_0000
`define TSSR_SRO_WMASK      32'h0007_0077
`define TSSR_TCC_RESET      32'h0000_0000
`define TSSR_SRO_RESET      32'h0000_0000

// Timer/capture select fields
`define TSSR_T2_CLKSEL_BIT  26
`define TSSR_T1_CLKSEL_BIT  25
`define TSSR_T0_CLKSEL_BIT  24
`define TSSR_T2_CAPSRC_BIT  20
`define TSSR_T1_CAPSRC_BIT  18

// Serial routing fields
`define TSSR_S2_OD_BIT      18
`define TSSR_S1_OD_BIT      17
`define TSSR_S0_OD_BIT      16
`define TSSR_S1_RXSRC_BIT   6
`define TSSR_S1_TXSRC_HI    5
`define TSSR_S1_TXSRC_LO    4
`define TSSR_S0_RXSRC_BIT   2
`define TSSR_S0_TXSRC_HI    1
`define TSSR_S0_TXSRC_LO    0

// Transmit source encodings
`define TSSR_TX_PLAIN       2'h0
`define TSSR_TX_MOD_T1      2'h1
`define TSSR_TX_MOD_T2      2'h2

`endif

// ===== tssr_pkg.sv
package tssr_pkg;

    // Routing choices for one serial port
    typedef struct packed {
        logic       open_drain;
        logic       rx_from_cmp;
        logic [1:0] tx_src;
    } tssr_serial_cfg_t;

    // Signals that one serial port exchanges with the routing
    typedef struct packed {
        logic rx_pin;
        logic tx_data;
    } tssr_serial_in_t;

    typedef struct packed {
        logic rx_data;
        logic tx_pin;
        logic tx_oe_n;
    } tssr_serial_out_t;

    // Comparator and timer channel 0 signals shared by the ports
    typedef struct packed {
        logic comparator_0_out;
        logic t1_ch0_out;
        logic t2_ch0_out;
    } tssr_shared_t;

endpackage : tssr_pkg

// ===== tssr_serial_route.sv
`timescale 1ns/10ps
`include "tssr_defs.svh"

module tssr_serial_route (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire tssr_pkg::tssr_serial_cfg_t cfg_i,
    input  wire tssr_pkg::tssr_serial_in_t  port_i,
    input  wire tssr_pkg::tssr_shared_t     shared_i,
    output tssr_pkg::tssr_serial_out_t      port_o
);
    import tssr_pkg::*;

    tssr_serial_out_t s_q;
    tssr_serial_out_t s_d;
    logic             tx_val;

    // Pick the data, then shape the pin drive; registered so outputs are glitch free
    always_comb begin
        tx_val = port_i.tx_data;
        case (cfg_i.tx_src)
            `TSSR_TX_MOD_T1: tx_val = port_i.tx_data & shared_i.t1_ch0_out;
            `TSSR_TX_MOD_T2: tx_val = port_i.tx_data & shared_i.t2_ch0_out;
            default:         tx_val = port_i.tx_data;                       // Reserved code sends plain
        endcase
        s_d         = s_q;
        s_d.rx_data = cfg_i.rx_from_cmp ? shared_i.comparator_0_out : port_i.rx_pin;
        s_d.tx_pin  = cfg_i.open_drain ? 1'b0 : tx_val;
        // Open drain only pulls low; a high bit releases the pin
        s_d.tx_oe_n = cfg_i.open_drain ? tx_val : 1'b0;
    end

    // Reset leaves a push-pull idle-high line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{rx_data: 1'b1, tx_pin: 1'b1, tx_oe_n: 1'b0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign port_o = s_q;

endmodule : tssr_serial_route

// ===== tssr_routing.sv
`timescale 1ns/10ps
`include "tssr_defs.svh"

module tssr_routing #(
    parameter int ADDR_W = 16
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    // Wishbone classic slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [ADDR_W-1:0]        wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // Timer clock and capture routing
    input  wire logic                     external_clock_pin_0_i,
    input  wire logic                     external_clock_pin_1_i,
    output logic      [2:0]               timer_ext_clock_o,
    input  wire logic                     timer1_channel0_pin_i,
    input  wire logic                     timer2_channel0_pin_i,
    output logic                          timer1_capture_o,
    output logic                          timer2_capture_o,
    input  wire tssr_pkg::tssr_shared_t   shared_i,
    // Serial ports
    input  wire tssr_pkg::tssr_serial_in_t serial0_i,
    input  wire tssr_pkg::tssr_serial_in_t serial1_i,
    input  wire tssr_pkg::tssr_serial_in_t serial2_i,
    output tssr_pkg::tssr_serial_out_t    serial0_o,
    output tssr_pkg::tssr_serial_out_t    serial1_o,
    output tssr_pkg::tssr_serial_out_t    serial2_o
);
    import tssr_pkg::*;

    // Offsets need 13 address bits; wider than 32 makes no sense on this bus
    if (ADDR_W < 13 || ADDR_W > 32) begin : g_bad_addr_w
        $error("tssr_routing: ADDR_W must be 13 to 32");
    end

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [31:0] tcc;
        logic [31:0] sro;
        logic [2:0]  ext_clk;
        logic        cap1;
        logic        cap2;
    } tssr_state_t;

    tssr_state_t      st_q;
    tssr_state_t      st_d;
    tssr_serial_cfg_t cfg0;
    tssr_serial_cfg_t cfg1;
    tssr_serial_cfg_t cfg2;
    logic             req;
    logic             hit_tcc;
    logic             hit_sro;
    logic [ADDR_W-1:0] word_adr;

    // Byte-lane merge, then drop reserved bits so they stay zero
    function automatic logic [31:0] wr_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel,
                                             input logic [31:0] wmask);
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return m & wmask;
    endfunction : wr_merge

    // Address decode on word boundaries
    always_comb begin
        req      = wb_cyc_i & wb_stb_i & ~st_q.ack;
        word_adr = {wb_adr_i[ADDR_W-1:2], 2'b00};
        hit_tcc  = 1'b0;
        hit_sro  = 1'b0;
        if (word_adr == ADDR_W'(`TSSR_TCC_OFF)) begin
            hit_tcc = 1'b1;
        end else if (word_adr == ADDR_W'(`TSSR_SRO_OFF)) begin
            hit_sro = 1'b1;
        end
    end

    // Per-port configuration taken straight from the serial routing register
    always_comb begin
        cfg0.open_drain  = st_q.sro[`TSSR_S0_OD_BIT];
        cfg0.rx_from_cmp = st_q.sro[`TSSR_S0_RXSRC_BIT];
        cfg0.tx_src      = st_q.sro[`TSSR_S0_TXSRC_HI:`TSSR_S0_TXSRC_LO];
        cfg1.open_drain  = st_q.sro[`TSSR_S1_OD_BIT];
        cfg1.rx_from_cmp = st_q.sro[`TSSR_S1_RXSRC_BIT];
        cfg1.tx_src      = st_q.sro[`TSSR_S1_TXSRC_HI:`TSSR_S1_TXSRC_LO];
        // Port 2 has no source selects, only the drive mode
        cfg2.open_drain  = st_q.sro[`TSSR_S2_OD_BIT];
        cfg2.rx_from_cmp = 1'b0;
        cfg2.tx_src      = `TSSR_TX_PLAIN;
    end

    // Bus handling and signal routing in one next-state block
    always_comb begin
        st_d       = st_q;
        st_d.ack   = req;
        st_d.rdata = 32'h0000_0000;
        if (req) begin
            if (hit_tcc) begin
                st_d.rdata = st_q.tcc;
                if (wb_we_i) begin
                    st_d.tcc = wr_merge(st_q.tcc, wb_dat_i, wb_sel_i, `TSSR_TCC_WMASK);
                end
            end else if (hit_sro) begin
                st_d.rdata = st_q.sro;
                if (wb_we_i) begin
                    st_d.sro = wr_merge(st_q.sro, wb_dat_i, wb_sel_i, `TSSR_SRO_WMASK);
                end
            end
        end
        // Unmapped addresses still ack, read zero and drop writes
        st_d.ext_clk[2] = st_q.tcc[`TSSR_T2_CLKSEL_BIT] ? external_clock_pin_1_i
                                                        : external_clock_pin_0_i;
        st_d.ext_clk[1] = st_q.tcc[`TSSR_T1_CLKSEL_BIT] ? external_clock_pin_1_i
                                                        : external_clock_pin_0_i;
        st_d.ext_clk[0] = st_q.tcc[`TSSR_T0_CLKSEL_BIT] ? external_clock_pin_1_i
                                                        : external_clock_pin_0_i;
        // Pin-side setup is software's job; the mux alone connects nothing
        st_d.cap2 = st_q.tcc[`TSSR_T2_CAPSRC_BIT] ? shared_i.comparator_0_out
                                                  : timer2_channel0_pin_i;
        st_d.cap1 = st_q.tcc[`TSSR_T1_CAPSRC_BIT] ? shared_i.comparator_0_out
                                                  : timer1_channel0_pin_i;
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q     <= '0;
            st_q.tcc <= `TSSR_TCC_RESET;
            st_q.sro <= `TSSR_SRO_RESET;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // Serial port routing, one instance per port
    tssr_serial_route u_serial0 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .cfg_i    (cfg0),
        .port_i   (serial0_i),
        .shared_i (shared_i),
        .port_o   (serial0_o)
    );

    tssr_serial_route u_serial1 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .cfg_i    (cfg1),
        .port_i   (serial1_i),
        .shared_i (shared_i),
        .port_o   (serial1_o)
    );

    tssr_serial_route u_serial2 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .cfg_i    (cfg2),
        .port_i   (serial2_i),
        .shared_i (shared_i),
        .port_o   (serial2_o)
    );

    assign wb_dat_o          = st_q.rdata;
    assign wb_ack_o          = st_q.ack;
    assign timer_ext_clock_o = st_q.ext_clk;
    assign timer1_capture_o  = st_q.cap1;
    assign timer2_capture_o  = st_q.cap2;

endmodule : tssr_routing

// ===== tssr_routing_assertions.sv
`timescale 1ns/10ps
`include "tssr_defs.svh"
module tssr_chk #(parameter int ADDR_W = 16) (
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      ce_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [ADDR_W-1:0]         wb_adr_i,
    input wire logic [3:0]                wb_sel_i,
    input wire logic [31:0]               wb_dat_i,
    input wire logic [31:0]               wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire logic                      external_clock_pin_0_i,
    input wire logic                      external_clock_pin_1_i,
    input wire logic [2:0]                timer_ext_clock_o,
    input wire logic                      timer1_channel0_pin_i,
    input wire logic                      timer2_channel0_pin_i,
    input wire logic                      timer1_capture_o,
    input wire logic                      timer2_capture_o,
    input wire tssr_pkg::tssr_shared_t    shared_i,
    input wire tssr_pkg::tssr_serial_in_t serial0_i,
    input wire tssr_pkg::tssr_serial_in_t serial1_i,
    input wire tssr_pkg::tssr_serial_in_t serial2_i,
    input wire tssr_pkg::tssr_serial_out_t serial0_o,
    input wire tssr_pkg::tssr_serial_out_t serial1_o,
    input wire tssr_pkg::tssr_serial_out_t serial2_o
);
    import tssr_pkg::*;
    logic [31:0] tcc_q, sro_q, wr_v, rd_v;
    logic [2:0] ext_e;
    logic [1:0] cap_e;
    logic take, hit_t, hit_s;
    tssr_serial_out_t e0, e1, e2;
    // Expected port outputs; open drain drives low only, so data moves to the enable
    function automatic tssr_serial_out_t ser(logic od, logic rxc, logic [1:0] ts, tssr_serial_in_t p, tssr_shared_t s);
        logic tx;
        tx = p.tx_data & (ts == 2'h1 ? s.t1_ch0_out : ts == 2'h2 ? s.t2_ch0_out : 1'b1);
        return '{rx_data: rxc ? s.comparator_0_out : p.rx_pin, tx_pin: od ? 1'b0 : tx, tx_oe_n: od ? tx : 1'b0};
    endfunction : ser
    // Request decode, shadowing the slave's own view
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
    assign hit_t = {wb_adr_i[ADDR_W-1:2], 2'b00} == ADDR_W'(`TSSR_TCC_OFF);
    assign hit_s = {wb_adr_i[ADDR_W-1:2], 2'b00} == ADDR_W'(`TSSR_SRO_OFF);
    assign rd_v = hit_t ? tcc_q : hit_s ? sro_q : 32'h0000_0000;
    assign ext_e = {tcc_q[26] ? external_clock_pin_1_i : external_clock_pin_0_i,
                    tcc_q[25] ? external_clock_pin_1_i : external_clock_pin_0_i,
                    tcc_q[24] ? external_clock_pin_1_i : external_clock_pin_0_i};
    assign cap_e = {tcc_q[20] ? shared_i.comparator_0_out : timer2_channel0_pin_i,
                    tcc_q[18] ? shared_i.comparator_0_out : timer1_channel0_pin_i};
    assign e0 = ser(sro_q[16], sro_q[2], sro_q[1:0], serial0_i, shared_i);
    assign e1 = ser(sro_q[17], sro_q[6], sro_q[5:4], serial1_i, shared_i);
    assign e2 = ser(sro_q[18], 1'b0, 2'h0, serial2_i, shared_i);
    // Byte-lane merge for the register mirror
    always_comb begin
        wr_v = hit_t ? tcc_q : sro_q;
        for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) wr_v[8*i+:8] = wb_dat_i[8*i+:8];
        end
    end
    // Register mirror; the masks drop reserved bits as the slave must
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tcc_q <= 32'h0000_0000;
            sro_q <= 32'h0000_0000;
        end else if (take && wb_we_i && hit_t) begin
            tcc_q <= wr_v & `TSSR_TCC_WMASK;
        end else if (take && wb_we_i && hit_s) begin
            sro_q <= wr_v & `TSSR_SRO_WMASK;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_take; take |=> wb_ack_o; endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack missing after request");
    property p_ack_once; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_read; take && !wb_we_i |=> wb_dat_o == $past(rd_v); endproperty
    a_read: assert property (p_read) else $error("read data wrong");
    property p_ext; ce_i && !rst_i |=> timer_ext_clock_o == $past(ext_e); endproperty
    a_ext: assert property (p_ext) else $error("timer clock routing wrong");
    property p_cap; ce_i && !rst_i |=> {timer2_capture_o, timer1_capture_o} == $past(cap_e); endproperty
    a_cap: assert property (p_cap) else $error("capture routing wrong");
    property p_s0; ce_i && !rst_i |=> serial0_o == $past(e0); endproperty
    a_s0: assert property (p_s0) else $error("serial port 0 routing wrong");
    property p_s1; ce_i && !rst_i |=> serial1_o == $past(e1); endproperty
    a_s1: assert property (p_s1) else $error("serial port 1 routing wrong");
    property p_s2; ce_i && !rst_i |=> serial2_o == $past(e2); endproperty
    a_s2: assert property (p_s2) else $error("serial port 2 routing wrong");
endmodule : tssr_chk
bind tssr_routing tssr_chk #(.ADDR_W(ADDR_W)) chk_u (.*);

// ===== tssr_far_model.sv
`timescale 1ns/10ps
module tssr_far_model (
    input  wire logic               clk_i,
    output logic [1:0]              clk_pins_o,
    output logic [1:0]              ch0_pins_o,
    output tssr_pkg::tssr_shared_t  shared_o,
    output tssr_pkg::tssr_serial_in_t serial0_o,
    output tssr_pkg::tssr_serial_in_t serial1_o,
    output tssr_pkg::tssr_serial_in_t serial2_o
);
    import tssr_pkg::*;
    logic [12:0] s_q = 13'h0001;
    // Odd step keeps every line toggling at its own rate; pins act as if port control selected them
    // Both timers count as capturing throughout, so the capture-source bits the bench sets stay legal
    always_ff @(posedge clk_i) begin
        s_q <= s_q + 13'h00B5;
    end
    assign {clk_pins_o, ch0_pins_o, shared_o, serial0_o, serial1_o, serial2_o} = s_q;
endmodule : tssr_far_model

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import tssr_pkg::*;
    typedef struct packed {logic [15:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] e;} tssr_row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, cap1, cap2;
    logic [15:0] adr = 16'h0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, dout, q;
    logic [1:0] cpin, chpin;
    logic [2:0] ext;
    tssr_shared_t sh;
    tssr_serial_in_t si0, si1, si2;
    tssr_serial_out_t so0, so1, so2;
    int n_mismatch = 0, checked = 0;
    // Writes with expected readback; covers masks, lanes, every transmit code, unmapped space
    localparam tssr_row_t rows [8] = '{
        '{16'h100C, 4'hF, 32'hFFFF_FFFF, 32'h0714_0000}, '{16'h100C, 4'h8, 32'h0000_0000, 32'h0014_0000},
        '{16'h100C, 4'hF, 32'h0500_0000, 32'h0500_0000}, '{16'h1010, 4'hF, 32'hFFFF_FFFF, 32'h0007_0077},
        '{16'h1010, 4'h5, 32'h0001_0011, 32'h0001_0011}, '{16'h1010, 4'hF, 32'h0002_0022, 32'h0002_0022},
        '{16'h1010, 4'h3, 32'h0000_0045, 32'h0002_0045}, '{16'h1014, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};
    always #2 clk_i = ~clk_i;
    tssr_far_model far_u (.clk_i(clk_i), .clk_pins_o(cpin), .ch0_pins_o(chpin), .shared_o(sh),
                          .serial0_o(si0), .serial1_o(si1), .serial2_o(si2));
    tssr_routing #(.ADDR_W(16)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout),
        .wb_ack_o(ack), .external_clock_pin_0_i(cpin[0]), .external_clock_pin_1_i(cpin[1]),
        .timer_ext_clock_o(ext), .timer1_channel0_pin_i(chpin[0]), .timer2_channel0_pin_i(chpin[1]),
        .timer1_capture_o(cap1), .timer2_capture_o(cap2), .shared_i(sh), .serial0_i(si0),
        .serial1_i(si1), .serial2_i(si2), .serial0_o(so0), .serial1_o(so1), .serial2_o(so2));
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One classic cycle, entered just after an edge; leaves one idle cycle behind it
    task automatic wb(input logic [15:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
        int n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = dout;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
        if (n >= 40) chk("ack_timeout", 32'h1, 32'h0);
    endtask : wb
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (18) @(posedge clk_i);
        chk("reset_outputs", 32'h0000_036C, {17'h0, ext, cap2, cap1, so0, so1, so2, ack});
        chk("reset_rdata", 32'h0000_0000, dout);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(rows[i].a, 1'b1, rows[i].s, rows[i].d);
            wb(rows[i].a, 1'b0, 4'hF, 32'h0000_0000);
            chk("readback", rows[i].e, q);
            repeat (6) @(posedge clk_i);
        end
        // Frozen clock enable must hold the request off, not lose it
        ce_i <= 1'b0;
        fork
            wb(16'h1010, 1'b0, 4'hF, 32'h0000_0000);
            begin
                repeat (3) @(posedge clk_i);
                chk("ack_frozen", 32'h0, {31'h0, ack});
                ce_i <= 1'b1;
            end
        join
        chk("frozen_read", 32'h0002_0045, q);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(16'h100C, 1'b0, 4'hF, 32'h0000_0000);
        chk("tcc_after_reset", 32'h0000_0000, q);
        wb(16'h1010, 1'b0, 4'hF, 32'h0000_0000);
        chk("sro_after_reset", 32'h0000_0000, q);
        conclude();
    end
endmodule : tb_top
